/* File: common/tda_pkg.sv */
// Function
// - Negative start temperature: offset code is temperature plus 128, sign flag bit 7 set.
// - Zero or positive start temperature: offset code is the temperature, bit 7 clear.
// - 8-bit mode: code equals measured temperature minus start temperature, one degree per step.
// - 10-bit mode: code is four times the difference, quarter degree per step.
// - Above full-scale temperature the thermal code saturates at its maximum.
// - Reference select bit: zero picks internal 2.28 V, one picks supply rail.
// - Two pin bits in config one make shared pins analog inputs one and two.
// - Analog results are 10-bit straight binary, step is reference over 1024.
// - Converter samples, then steps charge until comparator balances, then flags done.
// - Eight-bit offset register sets the temperature shown at zero volts.
// - Thermal resolution defaults to 8 bits; resolution bit set selects 10 bits.
// - Each completed temperature measurement updates the thermal DAC code.
package tda_pkg;
	localparam logic [7:0] TDA_ADDR_CFG_ONE = 8'h18;
	localparam logic [7:0] TDA_ADDR_CFG_THREE = 8'h1A;
	localparam logic [7:0] TDA_ADDR_TEMP_OFFSET = 8'h21;
	localparam logic [7:0] TDA_ADDR_AIN_RESULT_HI = 8'h40;
	localparam logic [7:0] TDA_ADDR_AIN_RESULT_LO = 8'h41;
	localparam logic [7:0] TDA_ADDR_THERMAL_HI = 8'h42;
	localparam logic [7:0] TDA_ADDR_THERMAL_LO = 8'h43;
	localparam int TDA_CFG1_PIN_LO = 1;
	localparam int TDA_CFG1_PIN_HI = 2;
	localparam int TDA_CFG3_RES_BIT = 1;
	localparam int TDA_CFG3_REF_BIT = 4;
	localparam int TDA_OFFSET_SIGN_BIT = 7;
	localparam logic [7:0] TDA_CFG_ONE_RESET = 8'h00;
	localparam logic [7:0] TDA_CFG_THREE_RESET = 8'h00;
	localparam logic [7:0] TDA_OFFSET_RESET = 8'hD8;
	localparam int TDA_OFFSET_BIAS = 128;
	localparam int TDA_AIN_BITS = 10;
	localparam int TDA_ACQ_NS = 1000;
	localparam int TDA_CLK_NS = 10;
	localparam int TDA_ACQ_CYCLES = (TDA_ACQ_NS + TDA_CLK_NS - 1) / TDA_CLK_NS;
	// Trial output register plus two-flop comparator sync
	localparam int TDA_SETTLE_CYCLES = 3;
	typedef enum logic [1:0] {TDA_IDLE, TDA_ACQUIRE, TDA_CONVERT} tda_sar_type;
endpackage

/* File: rtl/tda_sar.sv */
`timescale 1ns/1ns
`default_nettype none
module tda_sar
	import tda_pkg::*;
#(
	parameter int BITS = TDA_AIN_BITS,
	parameter int ACQ = TDA_ACQ_CYCLES
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic start,
	input wire logic comp_high,
	output logic sample_en,
	output logic [BITS-1:0] trial_code,
	output logic done,
	output logic [BITS-1:0] result
);
	tda_sar_type state_q;
	logic [15:0] acq_cnt_q;
	logic [BITS-1:0] bit_q;
	logic [BITS-1:0] code_q;
	logic [3:0] settle_q;
	// A decision taken before the synced comparator reflects the current trial would be stale
	wire logic settle_end = (settle_q == 4'(TDA_SETTLE_CYCLES));
	wire logic acq_end = (acq_cnt_q == 16'(ACQ - 1));
	wire logic [BITS-1:0] keep_code = comp_high ? code_q : (code_q & ~bit_q);
	assign trial_code = code_q;
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_q <= TDA_IDLE;
			acq_cnt_q <= 16'h0000;
			bit_q <= '0;
			code_q <= '0;
			done <= 1'b0;
			result <= '0;
			sample_en <= 1'b0;
			settle_q <= 4'h0;
		end else begin
			done <= 1'b0;
			unique case (state_q)
				TDA_IDLE: begin
					if (start) begin
						state_q <= TDA_ACQUIRE;
						sample_en <= 1'b1;
						acq_cnt_q <= 16'h0000;
					end
				end
				TDA_ACQUIRE: begin
					acq_cnt_q <= acq_cnt_q + 16'h0001;
					if (acq_end) begin
						sample_en <= 1'b0;
						state_q <= TDA_CONVERT;
						bit_q <= {1'b1, {(BITS-1){1'b0}}};
						code_q <= {1'b1, {(BITS-1){1'b0}}};
						settle_q <= 4'h0;
					end
				end
				TDA_CONVERT: begin
					// Comparator high means trial voltage still below input: keep the bit
					if (!settle_end) begin
						settle_q <= settle_q + 4'h1;
					end else begin
						settle_q <= 4'h0;
						if (bit_q[0]) begin
							result <= keep_code;
							done <= 1'b1;
							state_q <= TDA_IDLE;
						end else begin
							bit_q <= bit_q >> 1;
							code_q <= keep_code | (bit_q >> 1);
						end
					end
				end
			endcase
		end
	end
endmodule // tda_sar
`default_nettype wire

/* File: rtl/tda_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tda_top
	import tda_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic temp_valid,
	input wire logic signed [9:0] temp_quarter,
	input wire logic ain_start,
	input wire logic ain_comp_pin,
	output logic [9:0] thermal_code,
	output logic thermal_update,
	output logic ain_ref_select,
	output logic analog_input_one,
	output logic analog_input_two,
	output logic ain_sample_en,
	output logic [9:0] ain_trial_code,
	output logic ain_done,
	output logic [9:0] ain_result
);
	logic [7:0] cfg_one_q;
	logic [7:0] cfg_three_q;
	logic [7:0] offset_q;
	logic comp_meta_q;
	logic comp_sync_q;
	logic [9:0] sar_trial;
	logic sar_sample;
	logic sar_done;
	logic [9:0] sar_result;
	wire logic wr_cfg_one = reg_wr && (reg_addr == TDA_ADDR_CFG_ONE);
	wire logic wr_cfg_three = reg_wr && (reg_addr == TDA_ADDR_CFG_THREE);
	wire logic wr_offset = reg_wr && (reg_addr == TDA_ADDR_TEMP_OFFSET);
	wire logic res_ten = cfg_three_q[TDA_CFG3_RES_BIT];
	// Offset register decode: sign flag marks negative; low bits are temperature plus 128 when negative, the temperature otherwise
	wire logic off_neg = offset_q[TDA_OFFSET_SIGN_BIT];
	wire logic signed [9:0] start_deg = off_neg ?
		10'(signed'({3'b000, offset_q[6:0]}) - 10'sd128) :
		10'(signed'({3'b000, offset_q[6:0]}));
	// Work in quarter degrees; offset has one degree resolution
	wire logic signed [11:0] diff_q4 = 12'(temp_quarter) - 12'(start_deg * 4);
	wire logic signed [11:0] diff_deg = diff_q4 >>> 2;
	wire logic [9:0] code_eight = (diff_deg < 0) ? 10'h000 :
		(diff_deg > 12'sd255) ? 10'h0FF : 10'(diff_deg);
	wire logic [9:0] code_ten = (diff_q4 < 0) ? 10'h000 :
		(diff_q4 > 12'sd1023) ? 10'h3FF : 10'(diff_q4);
	wire logic [9:0] thermal_next = res_ten ? code_ten : code_eight;
	logic [7:0] rd_mux;
	always_comb begin
		unique case (reg_addr)
			TDA_ADDR_CFG_ONE: rd_mux = cfg_one_q;
			TDA_ADDR_CFG_THREE: rd_mux = cfg_three_q;
			TDA_ADDR_TEMP_OFFSET: rd_mux = offset_q;
			TDA_ADDR_AIN_RESULT_HI: rd_mux = ain_result[9:2];
			TDA_ADDR_AIN_RESULT_LO: rd_mux = {6'h00, ain_result[1:0]};
			TDA_ADDR_THERMAL_HI: rd_mux = thermal_code[9:2];
			TDA_ADDR_THERMAL_LO: rd_mux = {6'h00, thermal_code[1:0]};
			default: rd_mux = 8'h00;
		endcase
	end
	always_ff @(posedge core_clk) begin
		if (reset) begin
			cfg_one_q <= TDA_CFG_ONE_RESET;
			cfg_three_q <= TDA_CFG_THREE_RESET;
			offset_q <= TDA_OFFSET_RESET;
			reg_rdata <= 8'h00;
		end else begin
			if (wr_cfg_one)
				cfg_one_q <= reg_wdata;
			if (wr_cfg_three)
				cfg_three_q <= reg_wdata;
			if (wr_offset)
				offset_q <= reg_wdata;
			reg_rdata <= reg_rd ? rd_mux : 8'h00;
		end
	end
	always_ff @(posedge core_clk) begin
		if (reset) begin
			thermal_code <= 10'h000;
			thermal_update <= 1'b0;
			ain_ref_select <= 1'b0;
			analog_input_one <= 1'b0;
			analog_input_two <= 1'b0;
			comp_meta_q <= 1'b0;
			comp_sync_q <= 1'b0;
			ain_sample_en <= 1'b0;
			ain_trial_code <= 10'h000;
			ain_done <= 1'b0;
			ain_result <= 10'h000;
		end else begin
			thermal_update <= temp_valid;
			if (temp_valid)
				thermal_code <= thermal_next;
			ain_ref_select <= cfg_three_q[TDA_CFG3_REF_BIT];
			analog_input_one <= cfg_one_q[TDA_CFG1_PIN_LO];
			analog_input_two <= cfg_one_q[TDA_CFG1_PIN_HI];
			comp_meta_q <= ain_comp_pin;
			comp_sync_q <= comp_meta_q;
			// Registered copies add one cycle of latency to the converter pins
			ain_sample_en <= sar_sample;
			ain_trial_code <= sar_trial;
			ain_done <= sar_done;
			if (sar_done)
				ain_result <= sar_result;
		end
	end
	tda_sar #(.BITS(TDA_AIN_BITS), .ACQ(TDA_ACQ_CYCLES)) u_sar (
		.core_clk(core_clk),
		.reset(reset),
		.start(ain_start),
		.comp_high(comp_sync_q),
		.sample_en(sar_sample),
		.trial_code(sar_trial),
		.done(sar_done),
		.result(sar_result)
	);
endmodule // tda_top
`default_nettype wire

/* File: test/tda_ain_source.sv */
`timescale 1ns/1ns
`default_nettype none
module tda_ain_source (
	input wire logic [9:0] trial_code,
	input wire logic [10:0] level_half,
	output logic comp_high
);
	// Level held in half steps so the midway code transitions land exactly
	assign comp_high = ({1'b0, level_half} + 12'h001) >= {1'b0, trial_code, 1'b0};
endmodule // tda_ain_source
`default_nettype wire

/* File: test/tda_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module tda_checker
	import tda_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic temp_valid,
	input wire logic thermal_update,
	input wire logic [9:0] thermal_code,
	input wire logic ain_sample_en,
	input wire logic [9:0] ain_trial_code,
	input wire logic ain_done,
	input wire logic [9:0] ain_result
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	localparam int DONE_AFTER = TDA_ACQ_CYCLES + TDA_AIN_BITS * (TDA_SETTLE_CYCLES + 1);
	logic [7:0] acq_len_q;
	always_ff @(posedge core_clk) begin
		if (reset || !ain_sample_en) begin
			acq_len_q <= 8'h00;
		end else begin
			acq_len_q <= acq_len_q + 8'h01;
		end
	end
	sequence s_acq;
		ain_sample_en[*8];
	endsequence
	a_update_next: assert property (temp_valid |=> thermal_update) else $error("no update");
	a_update_cause: assert property (thermal_update |-> $past(temp_valid)) else $error("stray");
	a_code_hold: assert property (!$past(temp_valid) |-> $stable(thermal_code)) else $error("drift");
	a_acq_phase: assert property ($rose(ain_sample_en) |-> s_acq) else $error("short acq");
	a_conv_bound: assert property ($rose(ain_sample_en) |-> ##[DONE_AFTER:DONE_AFTER] ain_done)
		else $error("late");
	a_acq_length: assert property ($fell(ain_sample_en) |-> acq_len_q == 8'(TDA_ACQ_CYCLES))
		else $error("acquisition length");
	a_done_pulse: assert property (ain_done |=> !ain_done) else $error("done pulse");
	a_trial_first: assert property ($fell(ain_sample_en) |-> ain_trial_code == 10'h200) else $error("msb");
	a_done_quiet: assert property (ain_done |-> !ain_sample_en) else $error("done in acq");
	a_result_hold: assert property (!ain_done |-> $stable(ain_result)) else $error("result");
endmodule // tda_checker
bind tda_top tda_checker chk (.core_clk(core_clk), .reset(reset), .temp_valid(temp_valid),
	.thermal_update(thermal_update), .thermal_code(thermal_code), .ain_sample_en(ain_sample_en),
	.ain_trial_code(ain_trial_code), .ain_done(ain_done), .ain_result(ain_result));
`default_nettype wire

/* File: test/tb_thermal_dac_map_and_ain_config.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_thermal_dac_map_and_ain_config;
	import tda_pkg::*;
	logic core_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, temp_valid = 0, ain_start = 0, comp;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
	logic signed [9:0] temp_quarter = 0;
	logic [9:0] thermal_code, ain_trial_code, ain_result;
	logic [10:0] level = 0;
	logic thermal_update, ain_ref_select, pin_one, pin_two, ain_sample_en, ain_done;
	int mismatches = 0, checks_done = 0;
	int starts[5] = '{-128, -40, -1, 0, 127};
	always #5 core_clk = ~core_clk;
	tda_top dut (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .temp_valid(temp_valid),
		.temp_quarter(temp_quarter), .ain_start(ain_start), .ain_comp_pin(comp),
		.thermal_code(thermal_code), .thermal_update(thermal_update),
		.ain_ref_select(ain_ref_select), .analog_input_one(pin_one), .analog_input_two(pin_two),
		.ain_sample_en(ain_sample_en), .ain_trial_code(ain_trial_code), .ain_done(ain_done),
		.ain_result(ain_result));
	tda_ain_source src (.trial_code(ain_trial_code), .level_half(level), .comp_high(comp));
	task automatic chk(string n, logic [9:0] e, logic [9:0] s);
		checks_done++;
		if (s !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic xfer(bit w, logic [7:0] a, logic [7:0] d, output logic [7:0] q);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= w;
		reg_rd <= !w;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1 q = reg_rdata;
	endtask
	function automatic logic [7:0] enc(int t);
		return t < 0 ? {1'b1, 7'(t + 128)} : 8'(t);
	endfunction
	function automatic logic [9:0] exp_code(logic [7:0] s, bit ten, int tq);
		int d;
		d = tq - 4 * (s[7] ? int'(s[6:0]) - 128 : int'(s[6:0]));
		if (d < 0) d = 0;
		if (!ten) d = d / 4 > 255 ? 255 : d / 4;
		else if (d > 1023) d = 1023;
		return d[9:0];
	endfunction
	task report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		#100000;
		mismatches++;
		report_and_stop();
	end
	initial begin
		logic [7:0] q, cfg, off, pins;
		int n, tq;
		logic [9:0] ex;
		void'($urandom(32'h7052));
		repeat (10) @(posedge core_clk);
		reset <= 1'b0;
		xfer(0, TDA_ADDR_CFG_ONE, 0, q);
		chk("cfg_one", 10'(TDA_CFG_ONE_RESET), 10'(q));
		xfer(0, TDA_ADDR_CFG_THREE, 0, q);
		chk("cfg_three", 10'(TDA_CFG_THREE_RESET), 10'(q));
		xfer(0, TDA_ADDR_TEMP_OFFSET, 0, q);
		chk("offset", 10'(enc(-40)), 10'(q));
		xfer(0, 8'h7F, 0, q);
		chk("unmapped", 10'h000, 10'(q));
		$display("test reset values done");
		foreach (starts[i]) begin
			off = enc(starts[i]);
			cfg = i == 0 ? 8'h12 : i == 1 ? 8'h00 : 8'($urandom) & 8'h12;
			pins = i == 0 ? 8'h06 : i == 1 ? 8'h00 : 8'($urandom) & 8'h06;
			xfer(1, TDA_ADDR_CFG_ONE, pins, q);
			xfer(1, TDA_ADDR_CFG_THREE, cfg, q);
			xfer(1, TDA_ADDR_TEMP_OFFSET, off, q);
			chk("ref_select", 10'(cfg[4]), 10'(ain_ref_select));
			chk("pins", 10'(pins[2:1]), 10'({pin_two, pin_one}));
			for (int j = 0; j < 8; j++) begin
				tq = j == 0 ? 511 : j == 1 ? -512 : int'($signed(10'($urandom)));
				@(posedge core_clk);
				temp_quarter <= 10'(tq);
				temp_valid <= 1'b1;
				@(posedge core_clk);
				temp_valid <= 1'b0;
				ex = exp_code(off, cfg[1], tq);
				#1 chk("thermal", ex, thermal_code);
				chk("update", 10'h001, 10'(thermal_update));
			end
			xfer(0, TDA_ADDR_THERMAL_HI, 0, q);
			chk("thermal_hi", 10'(ex[9:2]), 10'(q));
			xfer(0, TDA_ADDR_THERMAL_LO, 0, q);
			chk("thermal_lo", 10'(ex[1:0]), 10'(q));
		end
		$display("test thermal map done");
		for (int j = 0; j < 6; j++) begin
			@(posedge core_clk);
			level <= j == 0 ? 11'h000 : j == 1 ? 11'h7FF : 11'($urandom);
			ain_start <= 1'b1;
			@(posedge core_clk);
			ain_start <= 1'b0;
			repeat (5) @(posedge core_clk);
			ain_start <= 1'b1;
			@(posedge core_clk);
			ain_start <= 1'b0;
			n = 0;
			do begin
				@(posedge core_clk);
				#1 n++;
			end while (ain_done !== 1'b1 && n < 300);
			ex = (level + 1) / 2 > 1023 ? 10'h3FF : 10'((level + 1) / 2);
			chk("ain_done", 10'h001, 10'(ain_done));
			chk("ain", ex, ain_result);
			xfer(0, TDA_ADDR_AIN_RESULT_HI, 0, q);
			chk("ain_hi", 10'(ex[9:2]), 10'(q));
			xfer(0, TDA_ADDR_AIN_RESULT_LO, 0, q);
			chk("ain_lo", 10'(ex[1:0]), 10'(q));
		end
		$display("test analog input done");
		report_and_stop();
	end
endmodule // tb_thermal_dac_map_and_ain_config
`default_nettype wire
